// >>> mcf_buf2.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module mcf_buf2 #(
    parameter int WIDTH = 12
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] head_q, tail_q;
    logic head_v_q, tail_v_q;
    wire push = in_valid && in_ready;
    wire pop = head_v_q && out_ready;
    assign in_ready = !tail_v_q;
    assign out_valid = head_v_q;
    assign out_data = head_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            head_v_q <= 1'b0;
            tail_v_q <= 1'b0;
            head_q <= '0;
            tail_q <= '0;
        end else if (pop) begin
            head_q <= tail_v_q ? tail_q : in_data;
            head_v_q <= tail_v_q || push;
            tail_q <= in_data;
            tail_v_q <= tail_v_q && push;
        end else if (push && !head_v_q) begin
            head_q <= in_data;
            head_v_q <= 1'b1;
        end else if (push) begin
            tail_q <= in_data;
            tail_v_q <= 1'b1;
        end
    end
endmodule : mcf_buf2

// >>> mcf_framer.sv
// maintenance channel update, interrupt flag and transmit sample timing
`timescale 1ns/100ps
`include "mcf_map.svh"
// What this block does
// - number frames 1-8, quats 1-120
// - M4 and M5/M6 update once per superframe
// - M5/M6 flag at end of frame 4
// - M4 flag at end of frame 8
// - eoc updates twice; flag per configuration
// - receive and transmit registers double buffered
// - overhead status updates with eoc at end
// - eoc flag b2, M4 flag b1
// - host derives write window from flags
// - frame-align pulse every 12 ms
// - NT transmit sync 60 quats after receive
// - one quat lasts 12.5 us
// - line marker 8 quats after sync pulse
// - M5/M6 interrupt only when b0 enabled
module mcf_framer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic nt_mode,
    input wire logic rx_sfs_pin,
    input wire logic sf_sync_pin,
    input wire mcf_pkg::mcf_byte_t rx_m4_word,
    input wire mcf_pkg::mcf_byte_t rx_m56_word,
    input wire mcf_pkg::mcf_byte_t rx_ovh_word,
    input wire mcf_pkg::mcf_eoc_t rx_eoc_word,
    input wire logic [1:0] maint_update_config,
    input wire mcf_pkg::mcf_nibble_t interrupt_enable_nibble,
    input wire mcf_pkg::mcf_nibble_t status_clear,
    input wire logic tx_frame_align_pulse_enable,
    input wire logic m4_tx_write,
    input wire logic m56_tx_write,
    input wire logic eoc_tx_write,
    input wire mcf_pkg::mcf_byte_t host_wdata,
    input wire mcf_pkg::mcf_eoc_t host_eoc_wdata,
    input wire logic eoc_rx_ready,
    output mcf_pkg::mcf_eoc_t eoc_word_reg,
    output logic eoc_rx_valid,
    output mcf_pkg::mcf_byte_t m4_receive_reg,
    output mcf_pkg::mcf_byte_t m56_channel_reg,
    output mcf_pkg::mcf_byte_t overhead_status_reg,
    output mcf_pkg::mcf_nibble_t interrupt_status_nibble,
    output logic irq_req,
    output mcf_pkg::mcf_byte_t tx_m4_frame,
    output mcf_pkg::mcf_byte_t tx_m56_frame,
    output mcf_pkg::mcf_eoc_t tx_eoc_frame,
    output logic tx_superframe_sync_pulse,
    output logic tx_frame_align_pulse,
    output logic line_sync_marker
);
    import mcf_pkg::*;

    localparam logic [6:0] QUAT_LAST = 7'(`MCF_QUAT_CYC - 1);

    logic rx_sfs_s1_q, rx_sfs_s2_q, rx_sfs_s3_q, sync_s1_q, sync_s2_q, rx_seen_q;
    logic [6:0] rx_tick_q, rx_quat_q, tx_tick_q, tx_quat_q;
    logic [3:0] rx_frame_q, tx_frame_q;
    mcf_tx_state_t tx_state_q;
    mcf_byte_t m4_rx_q, m56_rx_q, ovh_q, m4_tx_q, m56_tx_q, tx_m4_q, tx_m56_q;
    mcf_eoc_t eoc_tx_q, tx_eoc_q, eoc_pend_word_q;
    logic eoc_pend_q, buf_in_ready;
    mcf_nibble_t status_q;
    logic irq_q, tx_superframe_sync_pulse_q, tx_frame_align_pulse_q, marker_q;

    // decode of positions
    wire rx_sfs_evt = rx_sfs_s2_q && !rx_sfs_s3_q;
    wire rx_qend = rx_tick_q == QUAT_LAST;
    wire rx_fend = rx_qend && rx_quat_q == `MCF_QUATS_PER_FRAME;
    wire rx_f4_end = rx_fend && rx_frame_q == `MCF_MID_FRAME;
    wire rx_f8_end = rx_fend && rx_frame_q == `MCF_FRAMES;
    wire upd_f4 = rx_f4_end && sync_s2_q;
    wire upd_f8 = rx_f8_end && sync_s2_q;
    // no turnaround point until a received sync word has set the receive position
    wire nt_turn = rx_seen_q && rx_frame_q == 4'h1 && rx_quat_q == `MCF_TURN_QUATS && rx_qend;
    wire tx_run = tx_state_q == MCF_TX_RUN;
    wire tx_qend = tx_run && tx_tick_q == QUAT_LAST;
    wire tx_fend = tx_qend && tx_quat_q == `MCF_QUATS_PER_FRAME;
    wire tx_wrap = tx_fend && tx_frame_q == `MCF_FRAMES;
    wire tx_start = nt_mode ? nt_turn : (tx_wrap || !tx_run);
    wire tx_f4_end = tx_fend && tx_frame_q == `MCF_MID_FRAME;
    wire tx_frame_align_pulse_pt = tx_fend && tx_frame_q == `MCF_TX_FRAME_ALIGN_PULSE_FRAME;
    wire marker_pt = tx_qend && tx_frame_q == 4'h1 && tx_quat_q == `MCF_LINE_DELAY_QUATS;
    wire eoc_upd = upd_f4 || upd_f8;
    wire eoc_flag = (upd_f4 && maint_update_config[0]) || (upd_f8 && maint_update_config[1]);
    wire [3:0] status_set = {upd_f8, eoc_flag, upd_f8, upd_f4};
    wire [3:0] status_d = (status_q & ~status_clear) | status_set;
    wire irq_d = |(status_q & interrupt_enable_nibble);
    wire eoc_accept = eoc_pend_q && buf_in_ready;

    mcf_eoc_t buf_head;
    assign eoc_word_reg = buf_head;
    assign m4_receive_reg = m4_rx_q;
    assign m56_channel_reg = m56_rx_q;
    assign overhead_status_reg = ovh_q;
    assign interrupt_status_nibble = status_q;
    assign irq_req = irq_q;
    assign tx_m4_frame = tx_m4_q;
    assign tx_m56_frame = tx_m56_q;
    assign tx_eoc_frame = tx_eoc_q;
    assign tx_superframe_sync_pulse = tx_superframe_sync_pulse_q;
    assign tx_frame_align_pulse = tx_frame_align_pulse_q;
    assign line_sync_marker = marker_q;

    // pins pass two flops; the third only feeds the edge detector
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {rx_sfs_s1_q, rx_sfs_s2_q, rx_sfs_s3_q} <= 3'h0;
            {sync_s1_q, sync_s2_q} <= 2'h0;
            rx_seen_q <= 1'b0;
        end else begin
            {rx_sfs_s1_q, rx_sfs_s2_q, rx_sfs_s3_q} <= {rx_sfs_pin, rx_sfs_s1_q, rx_sfs_s2_q};
            rx_seen_q <= rx_seen_q || rx_sfs_evt;
            {sync_s1_q, sync_s2_q} <= {sf_sync_pin, sync_s1_q};
        end
    end

    // receive position, realigned on each received sync word
    always_ff @(posedge clk) begin
        if (sys_rst || rx_sfs_evt) begin
            rx_tick_q <= 7'h00;
            rx_quat_q <= 7'h01;
            rx_frame_q <= 4'h1;
        end else begin
            rx_tick_q <= rx_qend ? 7'h00 : rx_tick_q + 7'h01;
            if (rx_fend) begin
                rx_quat_q <= 7'h01;
                rx_frame_q <= rx_frame_q == `MCF_FRAMES ? 4'h1 : rx_frame_q + 4'h1;
            end else if (rx_qend) begin
                rx_quat_q <= rx_quat_q + 7'h01;
            end
        end
    end

    // transmit position: NT follows the turnaround point, LT runs free
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_state_q <= MCF_TX_HOLD;
            tx_tick_q <= 7'h00;
            tx_quat_q <= 7'h01;
            tx_frame_q <= 4'h1;
        end else if (tx_start) begin
            tx_state_q <= MCF_TX_RUN;
            tx_tick_q <= 7'h00;
            tx_quat_q <= 7'h01;
            tx_frame_q <= 4'h1;
        end else if (tx_run) begin
            tx_tick_q <= tx_qend ? 7'h00 : tx_tick_q + 7'h01;
            if (tx_fend) begin
                tx_quat_q <= 7'h01;
                tx_frame_q <= tx_wrap ? 4'h1 : tx_frame_q + 4'h1;
            end else if (tx_qend) begin
                tx_quat_q <= tx_quat_q + 7'h01;
            end
        end
    end

    // receive side: stable copies change only at the update points
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            m4_rx_q <= `MCF_BYTE_RST;
            m56_rx_q <= `MCF_M56_RST;
            ovh_q <= `MCF_BYTE_RST;
            status_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            if (upd_f8) m4_rx_q <= rx_m4_word;
            if (upd_f4) m56_rx_q <= rx_m56_word;
            if (upd_f8) ovh_q <= rx_ovh_word;
            status_q <= status_d;
            irq_q <= irq_d;
        end
    end

    // eoc words wait here until the buffer takes them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            eoc_pend_q <= 1'b0;
            eoc_pend_word_q <= `MCF_EOC_RST;
        end else if (eoc_upd) begin
            eoc_pend_q <= 1'b1;
            eoc_pend_word_q <= rx_eoc_word;
        end else if (eoc_accept) begin
            eoc_pend_q <= 1'b0;
        end
    end

    mcf_buf2 #(.WIDTH(12)) u_eoc_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(eoc_pend_q),
        .in_ready(buf_in_ready),
        .in_data(eoc_pend_word_q),
        .out_valid(eoc_rx_valid),
        .out_ready(eoc_rx_ready),
        .out_data(buf_head)
    );

    // transmit side: host shadows copied into the frame at sample points
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            m4_tx_q <= `MCF_BYTE_RST;
            m56_tx_q <= `MCF_M56_RST;
            eoc_tx_q <= `MCF_EOC_RST;
            tx_m4_q <= `MCF_BYTE_RST;
            tx_m56_q <= `MCF_M56_RST;
            tx_eoc_q <= `MCF_EOC_RST;
        end else begin
            if (m4_tx_write) m4_tx_q <= host_wdata;
            if (m56_tx_write) m56_tx_q <= host_wdata;
            if (eoc_tx_write) eoc_tx_q <= host_eoc_wdata;
            if (tx_start) tx_m4_q <= m4_tx_q;
            if (tx_start) tx_m56_q <= m56_tx_q;
            if (tx_start || tx_f4_end) tx_eoc_q <= eoc_tx_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_superframe_sync_pulse_q <= 1'b0;
            tx_frame_align_pulse_q <= 1'b0;
            marker_q <= 1'b0;
        end else begin
            tx_superframe_sync_pulse_q <= tx_start;
            tx_frame_align_pulse_q <= tx_frame_align_pulse_enable && tx_frame_align_pulse_pt;
            marker_q <= marker_pt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_quat_range: assert property (rx_quat_q >= 7'h01 && rx_quat_q <= `MCF_QUATS_PER_FRAME)
        else $error("receive quat out of range");
    a_m56_flag_f4: assert property ($rose(status_q[`MCF_ST_M56]) |-> $past(rx_f4_end))
        else $error("m56 flag set away from frame 4 end");
    a_m4_flag_f8: assert property ($rose(status_q[`MCF_ST_M4]) |-> $past(rx_f8_end && sync_s2_q))
        else $error("m4 flag set away from frame 8 end");
    a_m4_rx_stable: assert property ($changed(m4_rx_q) |-> $past(rx_f8_end))
        else $error("m4 receive word changed between updates");
    a_ovh_with_eoc: assert property (upd_f8 |=> eoc_pend_q && ovh_q == $past(rx_ovh_word))
        else $error("overhead not updated with eoc");
    a_flag_set_wins: assert property (status_set[`MCF_ST_EOC] |=> status_q[`MCF_ST_EOC])
        else $error("eoc flag lost against clear");
    a_irq_gate: assert property (irq_q |-> $past(|(status_q & interrupt_enable_nibble)))
        else $error("interrupt without enabled flag");
    a_tx_double_buf: assert property ($changed(tx_m4_q) |-> $past(tx_start))
        else $error("transmit m4 word changed off sample point");
    a_nt_turnaround: assert property (nt_mode && tx_superframe_sync_pulse_q |->
        rx_frame_q == 4'h1 && rx_quat_q == `MCF_TURN_QUATS + 7'h01 && rx_tick_q == 7'h00)
        else $error("transmit sync not 60 quats after receive sync");
    a_line_marker: assert property (marker_q |->
        tx_frame_q == 4'h1 && tx_quat_q == `MCF_LINE_DELAY_QUATS + 7'h01 && tx_tick_q == 7'h00)
        else $error("line marker not 8 quats after sync pulse");

    c_eoc_f4: cover property (upd_f4 && maint_update_config[0]);
    c_m4_flag: cover property ($rose(status_q[`MCF_ST_M4]));
    c_buf_full: cover property (eoc_pend_q && !buf_in_ready);
    c_marker: cover property (marker_q);
    c_lt_start: cover property (!nt_mode && tx_superframe_sync_pulse_q);
endmodule : mcf_framer

// >>> mcf_map.svh
// timing counts, positions and reset values of the maintenance channel framer
`ifndef MCF_MAP_SVH
`define MCF_MAP_SVH
`define MCF_CLK_NS 100
`define MCF_QUAT_NS 12500
`define MCF_QUAT_CYC (`MCF_QUAT_NS / `MCF_CLK_NS)
`define MCF_QUATS_PER_FRAME 7'h78
`define MCF_FRAMES 4'h8
`define MCF_MID_FRAME 4'h4
`define MCF_TURN_QUATS 7'h3c
`define MCF_LINE_DELAY_QUATS 7'h08
`define MCF_TX_FRAME_ALIGN_PULSE_FRAME 4'h7
`define MCF_ST_M56 0
`define MCF_ST_M4 1
`define MCF_ST_EOC 2
`define MCF_ST_OVH 3
`define MCF_M56_RST 8'hff
`define MCF_BYTE_RST 8'h00
`define MCF_EOC_RST 12'h000
`endif

// >>> mcf_pkg.sv
// types of the maintenance channel framer
package mcf_pkg;
    typedef enum logic {MCF_TX_HOLD, MCF_TX_RUN} mcf_tx_state_t;
    typedef logic [11:0] mcf_eoc_t;
    typedef logic [7:0] mcf_byte_t;
    typedef logic [3:0] mcf_nibble_t;
endpackage : mcf_pkg

// >>> mcf_remote.sv
// far-end transceiver model: superframe sync, sync status and deframed words
`timescale 1ns/100ps
module mcf_remote (
    input wire logic clk,
    input wire logic sys_rst,
    output logic rx_sfs_pin,
    output logic sf_sync_pin,
    output mcf_pkg::mcf_byte_t rx_m4_word,
    output mcf_pkg::mcf_byte_t rx_m56_word,
    output mcf_pkg::mcf_byte_t rx_ovh_word,
    output mcf_pkg::mcf_eoc_t rx_eoc_word
);
    import mcf_pkg::*;
    logic [16:0] cyc_q;
    mcf_byte_t sf_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cyc_q <= 17'h0_0000;
            sf_q <= 8'h00;
            rx_sfs_pin <= 1'b0;
            sf_sync_pin <= 1'b0;
            rx_m4_word <= 8'h00;
            rx_m56_word <= 8'h00;
            rx_ovh_word <= 8'h00;
            rx_eoc_word <= 12'h000;
        end else begin
            // 8 frames of 120 quats of 125 cycles
            cyc_q <= (cyc_q == 17'h1_d4bf) ? 17'h0_0000 : cyc_q + 17'h0_0001;
            if (cyc_q == 17'h1_d4bf) sf_q <= sf_q + 8'h01;
            rx_sfs_pin <= (cyc_q < 17'h0_0004);
            sf_sync_pin <= 1'b1;
            // words change well away from the update points
            if (cyc_q == 17'h0_0064) begin
                rx_m4_word <= sf_q ^ 8'hc3;
                rx_m56_word <= sf_q ^ 8'h69;
                rx_ovh_word <= sf_q ^ 8'h3c;
                rx_eoc_word <= {4'h5, sf_q};
            end
            if (cyc_q == 17'h0_eac4) rx_eoc_word <= {4'ha, sf_q};
        end
    end
endmodule : mcf_remote

// >>> tb_maint_channel_irq_update_timing.sv
// self-checking bench of the maintenance channel framer
`timescale 1ns/100ps
module tb_maint_channel_irq_update_timing;
    import mcf_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic nt_mode = 1'b1;
    logic tx_frame_align_pulse_enable = 1'b1;
    logic [1:0] maint_update_config = 2'b11;
    logic m4_tx_write = 1'b0, m56_tx_write = 1'b0, eoc_tx_write = 1'b0, eoc_rx_ready = 1'b0;
    mcf_nibble_t interrupt_enable_nibble = 4'h0, status_clear = 4'h0, interrupt_status_nibble;
    mcf_byte_t host_wdata = 8'h00;
    mcf_eoc_t host_eoc_wdata = 12'h000;
    logic rx_sfs_pin, sf_sync_pin, eoc_rx_valid, irq_req;
    logic tx_superframe_sync_pulse, tx_frame_align_pulse, line_sync_marker;
    mcf_byte_t rx_m4_word, rx_m56_word, rx_ovh_word, m4_receive_reg, m56_channel_reg, overhead_status_reg;
    mcf_byte_t tx_m4_frame, tx_m56_frame, e4, e56, eovh;
    mcf_eoc_t rx_eoc_word, eoc_word_reg, tx_eoc_frame, e1, e2;
    int miscompares = 0, cmp_count = 0, cyc = 0, rx_c = 0, ts_c = 0, fa_c = 0, lm_c = 0, rl_c = 0, t0, ts1;
    mcf_framer i_mcf_framer (.clk, .sys_rst, .nt_mode, .rx_sfs_pin, .sf_sync_pin, .rx_m4_word, .rx_m56_word,
        .rx_ovh_word, .rx_eoc_word, .maint_update_config, .interrupt_enable_nibble, .status_clear, .tx_frame_align_pulse_enable,
        .m4_tx_write, .m56_tx_write, .eoc_tx_write, .host_wdata, .host_eoc_wdata, .eoc_rx_ready, .eoc_word_reg,
        .eoc_rx_valid, .m4_receive_reg, .m56_channel_reg, .overhead_status_reg, .interrupt_status_nibble,
        .irq_req, .tx_m4_frame, .tx_m56_frame, .tx_eoc_frame, .tx_superframe_sync_pulse, .tx_frame_align_pulse,
        .line_sync_marker);
    mcf_remote i_mcf_remote (.clk, .sys_rst, .rx_sfs_pin, .sf_sync_pin, .rx_m4_word, .rx_m56_word,
        .rx_ovh_word, .rx_eoc_word);
    always #50 clk = ~clk;
    // timestamps of the line and transmit events
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rx_sfs_pin === 1'b1 && rx_c == 0) rx_c <= cyc;
        if (tx_superframe_sync_pulse === 1'b1) ts_c <= cyc;
        if (tx_frame_align_pulse === 1'b1) fa_c <= cyc;
        if (line_sync_marker === 1'b1) lm_c <= cyc;
        if (rx_sfs_pin === 1'b1) rl_c <= cyc;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic wait_to(input int n);
        while (cyc < n) @(posedge clk);
        #1;
    endtask : wait_to
    task automatic pop_eoc;
        @(posedge clk) eoc_rx_ready <= 1'b1;
        @(posedge clk) eoc_rx_ready <= 1'b0;
        wait_to(cyc + 3);
    endtask : pop_eoc
    task automatic close_out;
        $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    initial begin
        #14_000_000;
        miscompares++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        wait_to(40);
        t0 = rx_c;
        wait_to(t0 + 200);
        e4 = rx_m4_word;
        e56 = rx_m56_word;
        eovh = rx_ovh_word;
        e1 = rx_eoc_word;
        wait_to(t0 + 8600);
        ts1 = ts_c;
        check("turnaround", (ts1 - t0 >= 7500) && (ts1 - t0 <= 7506), 1);
        check("line_marker", lm_c - ts1, 1000);
        check("tx_m56_init", tx_m56_frame, 8'hff);
        $display("test tx_timing done");
        wait_to(t0 + 59990);
        check("m56_before", m56_channel_reg, 8'hff);
        wait_to(t0 + 60010);
        check("m56_frame4", m56_channel_reg, e56);
        check("status_frame4", interrupt_status_nibble, 4'h5);
        check("irq_masked", irq_req, 1'b0);
        check("eoc_valid", eoc_rx_valid, 1'b1);
        check("m4_not_yet", m4_receive_reg, 8'h00);
        @(posedge clk) interrupt_enable_nibble <= 4'h1;
        wait_to(cyc + 3);
        check("irq_enabled", irq_req, 1'b1);
        // read acknowledge and load the outgoing shadows in the same cycle
        @(posedge clk) begin
            status_clear <= 4'hf;
            interrupt_enable_nibble <= 4'he;
            {m4_tx_write, m56_tx_write, eoc_tx_write} <= 3'h7;
            host_wdata <= 8'h5a;
            host_eoc_wdata <= 12'h3c3;
        end
        @(posedge clk) begin
            status_clear <= 4'h0;
            {m4_tx_write, m56_tx_write, eoc_tx_write} <= 3'h0;
        end
        wait_to(t0 + 60200);
        e2 = rx_eoc_word;
        check("status_cleared", interrupt_status_nibble, 4'h0);
        check("tx_m4_held", tx_m4_frame, 8'h00);
        check("tx_eoc_held", tx_eoc_frame, 12'h000);
        $display("test frame4 done");
        wait_to(t0 + 120010);
        check("m4_frame8", m4_receive_reg, e4);
        check("ovh_frame8", overhead_status_reg, eovh);
        check("status_frame8", interrupt_status_nibble, 4'he);
        check("irq_frame8", irq_req, 1'b1);
        check("eoc_first", eoc_word_reg, e1);
        pop_eoc();
        check("eoc_second", eoc_word_reg, e2);
        check("eoc_valid2", eoc_rx_valid, 1'b1);
        pop_eoc();
        check("eoc_empty", eoc_rx_valid, 1'b0);
        $display("test frame8 done");
        wait_to(t0 + 127700);
        check("tx_period", ts_c - ts1, 120000);
        check("frame_align", (fa_c - ts1 >= 104990) && (fa_c - ts1 <= 105010), 1);
        check("tx_m4_next", tx_m4_frame, 8'h5a);
        check("tx_m56_next", tx_m56_frame, 8'h5a);
        check("tx_eoc_next", tx_eoc_frame, 12'h3c3);
        $display("test transmit done");
        // second reset into LT mode: transmit free runs from release
        @(posedge clk) begin
            sys_rst <= 1'b1;
            nt_mode <= 1'b0;
        end
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t0 = cyc;
        wait_to(t0 + 2);
        check("rst_m56", m56_channel_reg, 8'hff);
        check("rst_tx_m56", tx_m56_frame, 8'hff);
        check("rst_m4", m4_receive_reg, 8'h00);
        check("rst_status", interrupt_status_nibble, 4'h0);
        check("rst_eoc_valid", eoc_rx_valid, 1'b0);
        wait_to(t0 + 1100);
        check("lt_tx_start", ts_c - t0, 2);
        check("lt_marker", lm_c - ts_c, 1000);
        check("lt_rx_lag", (rl_c >= ts_c) && (rl_c - ts_c <= 8500), 1);
        $display("test lt_mode done");
        close_out();
    end
endmodule : tb_maint_channel_irq_update_timing
